// *** inc/scp_pkg.sv ***
// Purpose: Shared constants for the serial controller, clock phase one
// Assumes: 50 MHz bus clock, 20 ns period
// Notes: Field positions of the configuration words live here
package scp_pkg;
	// ************************************************************
	// Configuration word fields
	// ************************************************************
	localparam int GCR_CTRL_BIT = 0;
	localparam int FMT_PS_LSB = 8;
	localparam int FMT_PS_MSB = 15;
	localparam int FMT_PHASE_BIT = 16;
	localparam int FMT_POL_BIT = 17;
	localparam int DLY_W = 8;
	localparam int DLY_C2T_LSB = 24;
	localparam int DLY_T2C_LSB = 16;
	localparam int PS_W = 8;
	localparam int CNT_W = 10;

	// ************************************************************
	// Timing
	// ************************************************************
	localparam int CLK_PERIOD_NS = 20;
	localparam int MIN_SCLK_NS = 25;
	localparam logic [CNT_W-1:0] MIN_SCLK_CYC =
		CNT_W'((MIN_SCLK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [CNT_W-1:0] PS_ZERO_CYC = 10'h002;
	localparam logic [CNT_W-1:0] SETUP_EXTRA = 10'h002;
	localparam logic [CNT_W-1:0] SETUP_HOLD_EXTRA = 10'h003;
	localparam logic [CNT_W-1:0] RELEASE_EXTRA = 10'h001;
	localparam int WORD_W = 16;

	// ************************************************************
	// Sequencer states
	// ************************************************************
	typedef enum logic [1:0] {
		SCP_IDLE = 2'b00,
		SCP_SETUP = 2'b01,
		SCP_SHIFT = 2'b10,
		SCP_RELEASE = 2'b11
	} scp_state_t;
endpackage

// *** inc/scp_tick_if.sv ***
// Purpose: Carrier between sequencer and serial clock divider
// Assumes: Single bus clock domain
// Notes: lead and trail are one-cycle pulses
`timescale 1ns/10ps
`default_nettype none
interface scp_tick_if;
	logic [scp_pkg::PS_W-1:0] prescale;
	logic run;
	logic lead;
	logic trail;
	modport gen (input prescale, input run, output lead, output trail);
	modport user (output prescale, output run, input lead, input trail);
endinterface
`default_nettype wire

// *** logic/scp_clkgen.sv ***
// Purpose: Serial clock divider giving edge enable pulses
// Assumes: run held high for a whole word
// Notes: lead ends the first half period, trail the second
`timescale 1ns/10ps
`default_nettype none
module scp_clkgen
(
	input wire logic i_mclk,
	input wire logic i_reset,
	scp_tick_if.gen tick
);
	import scp_pkg::*;

	logic [CNT_W-1:0] cnt_reg;
	logic [CNT_W-1:0] cnt_next;
	wire [CNT_W-1:0] raw_period;
	wire [CNT_W-1:0] period;
	wire [CNT_W-1:0] half;

	// ************************************************************
	// Period decode
	// ************************************************************
	// (R2) zero prescale
	assign raw_period = (tick.prescale == 8'h00) ? PS_ZERO_CYC
		: CNT_W'(tick.prescale) + 10'h001;
	// (R1) floor at minimum
	assign period = (raw_period < MIN_SCLK_CYC) ? MIN_SCLK_CYC
		: raw_period;
	// (R6) first half rounded down
	assign half = period >> 1;
	assign cnt_next = (cnt_reg == period - 10'h001) ? 10'h000
		: cnt_reg + 10'h001;
	assign tick.lead = tick.run && (cnt_reg == half - 10'h001);
	assign tick.trail = tick.run && (cnt_reg == period - 10'h001);

	always_ff @(posedge i_mclk)
	begin
		if (i_reset || !tick.run)
			cnt_reg <= 10'h000;
		else
			cnt_reg <= cnt_next;
	end
endmodule
`default_nettype wire

// *** logic/scp_controller.sv ***
// Purpose: Serial controller, clock phase one, with select timing
// Assumes: Configuration words are plain inputs; bus clock only
// Notes: Settings are captured when a transfer starts
// What this block does
// (R1) Prescale 1..255 gives period of prescale+1 bus cycles, at least 25 ns.
// (R2) Prescale zero gives a serial clock period of two bus cycles.
// (R3) Prescale is taken from format word bits 15 to 8.
// (R4) Runs only with controller bit 0 and phase bit 16 set.
// (R5) Format bit 17 sets clock polarity and thus the active edge.
// (R6) First clock phase lasts half the period rounded down, the second phase the rest.
// (R7) Each outgoing bit is driven half a period before the active edge.
// (R8) Incoming data is sampled on the active edge.
// (R9) Polarity zero: select to first edge is half period plus delay+2.
// (R10) Polarity one: half period plus delay+2, or delay+3 with select hold set.
// (R11) Select stays asserted release delay+1 cycles after the last edge.
// (R12) Setup and release delays come from the delay configuration word.
// (R13) With select hold set, select stays asserted between words.
`timescale 1ns/10ps
`default_nettype none
module scp_controller
#(
	parameter int W = scp_pkg::WORD_W
)
(
	input wire logic i_mclk,
	input wire logic i_reset,
	input wire logic [31:0] i_global_control_reg,
	input wire logic [31:0] i_format_config_reg,
	input wire logic [31:0] i_select_delay_reg,
	input wire logic i_select_hold_enable,
	input wire logic i_tx_valid,
	input wire logic [W-1:0] i_tx_data,
	input wire logic i_target_out_data,
	output logic o_tx_ready,
	output logic o_rx_valid,
	output logic [W-1:0] o_rx_data,
	output logic o_busy,
	output logic o_serial_clock_out,
	output logic o_controller_out_data,
	output logic o_select_n
);
	import scp_pkg::*;

	scp_tick_if tick ();

	scp_clkgen u_clkgen
	(
		.i_mclk(i_mclk),
		.i_reset(i_reset),
		.tick(tick)
	);

	scp_state_t state_reg;
	scp_state_t state_next;
	logic [CNT_W-1:0] cnt_reg;
	logic [CNT_W-1:0] cnt_next;
	logic [W-1:0] shift_reg;
	logic [W-1:0] shift_next;
	logic [$clog2(W+1)-1:0] bits_reg;
	logic [$clog2(W+1)-1:0] bits_next;
	logic pol_reg;
	logic hold_reg;
	logic pend_reg;
	logic pend_next;
	logic [PS_W-1:0] ps_reg;
	logic [DLY_W-1:0] t2c_reg;
	logic ready_reg;
	logic rxv_reg;
	logic [W-1:0] rxd_reg;
	logic busy_reg;
	logic sclk_reg;
	logic sclk_next;
	logic mosi_reg;
	logic mosi_next;
	logic sel_n_reg;
	logic ready_next;

	wire enabled;
	wire take;
	wire start;
	wire pol_in;
	wire [DLY_W-1:0] c2t_in;
	wire [CNT_W-1:0] setup_cyc;
	wire last_bit;
	wire rel_done;

	// ************************************************************
	// Configuration decode
	// ************************************************************
	// (R4) mode gate
	assign enabled = i_global_control_reg[GCR_CTRL_BIT]
		&& i_format_config_reg[FMT_PHASE_BIT];
	// (R5) polarity select
	assign pol_in = i_format_config_reg[FMT_POL_BIT];
	// (R12) delay fields
	assign c2t_in = i_select_delay_reg[DLY_C2T_LSB +: DLY_W];
	// (R9) setup count
	// (R10) hold adds one
	assign setup_cyc = CNT_W'(c2t_in)
		+ ((pol_in && i_select_hold_enable) ? SETUP_HOLD_EXTRA
		: SETUP_EXTRA);
	assign take = i_tx_valid && ready_reg;
	assign start = take && (state_reg == SCP_IDLE);
	assign last_bit = (bits_reg == ($clog2(W+1))'(W - 1));
	assign rel_done = (cnt_reg == 10'h001);
	// (R3) prescale field
	assign tick.prescale = ps_reg;
	assign tick.run = (state_reg == SCP_SHIFT);

	// ************************************************************
	// Sequencer next state
	// ************************************************************
	always_comb
	begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		shift_next = shift_reg;
		bits_next = bits_reg;
		pend_next = pend_reg;
		sclk_next = sclk_reg;
		mosi_next = mosi_reg;
		case (state_reg)
			SCP_IDLE:
			begin
				sclk_next = pol_in;
				if (start)
				begin
					state_next = SCP_SETUP;
					cnt_next = setup_cyc;
					shift_next = i_tx_data;
					bits_next = '0;
					mosi_next = i_tx_data[W-1];
				end
			end
			SCP_SETUP:
			begin
				cnt_next = cnt_reg - 10'h001;
				if (cnt_reg == 10'h001)
					state_next = SCP_SHIFT;
			end
			SCP_SHIFT:
			begin
				// (R7) drive half period early
				if (tick.lead)
				begin
					sclk_next = ~pol_reg;
					mosi_next = shift_reg[W-1];
				end
				// (R8) sample on active edge
				if (tick.trail)
				begin
					sclk_next = pol_reg;
					shift_next = {shift_reg[W-2:0], i_target_out_data};
					bits_next = bits_reg + 1'b1;
					if (last_bit)
					begin
						state_next = SCP_RELEASE;
						// (R11) release count
						cnt_next = CNT_W'(t2c_reg) + RELEASE_EXTRA;
					end
				end
			end
			SCP_RELEASE:
			begin
				cnt_next = cnt_reg - 10'h001;
				if (take)
				begin
					pend_next = 1'b1;
					shift_next = i_tx_data;
				end
				if (rel_done)
				begin
					// (R13) keep select for next word
					if (pend_reg || take)
					begin
						state_next = SCP_SHIFT;
						bits_next = '0;
						pend_next = 1'b0;
					end
					else
						state_next = SCP_IDLE;
				end
			end
			default:
				state_next = SCP_IDLE;
		endcase
	end

	assign ready_next = enabled && ((state_next == SCP_IDLE)
		|| (state_next == SCP_RELEASE && hold_reg && !pend_next));

	// ************************************************************
	// Registers
	// ************************************************************
	always_ff @(posedge i_mclk)
	begin
		if (i_reset)
		begin
			state_reg <= SCP_IDLE;
			cnt_reg <= 10'h000;
			shift_reg <= '0;
			bits_reg <= '0;
			pend_reg <= 1'b0;
			sclk_reg <= 1'b0;
			mosi_reg <= 1'b0;
			ready_reg <= 1'b0;
		end
		else
		begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			shift_reg <= shift_next;
			bits_reg <= bits_next;
			pend_reg <= pend_next;
			sclk_reg <= sclk_next;
			mosi_reg <= mosi_next;
			ready_reg <= ready_next;
		end
	end

	// Settings captured at transfer start
	always_ff @(posedge i_mclk)
	begin
		if (i_reset)
		begin
			pol_reg <= 1'b0;
			hold_reg <= 1'b0;
			ps_reg <= 8'h00;
			t2c_reg <= 8'h00;
		end
		else if (start)
		begin
			pol_reg <= pol_in;
			hold_reg <= i_select_hold_enable;
			ps_reg <= i_format_config_reg[FMT_PS_MSB:FMT_PS_LSB];
			t2c_reg <= i_select_delay_reg[DLY_T2C_LSB +: DLY_W];
		end
	end

	// Select, receive word and status
	always_ff @(posedge i_mclk)
	begin
		if (i_reset)
		begin
			sel_n_reg <= 1'b1;
			rxv_reg <= 1'b0;
			rxd_reg <= '0;
			busy_reg <= 1'b0;
		end
		else
		begin
			sel_n_reg <= (state_next == SCP_IDLE);
			busy_reg <= (state_next != SCP_IDLE);
			rxv_reg <= (state_reg == SCP_SHIFT) && tick.trail && last_bit;
			if ((state_reg == SCP_SHIFT) && tick.trail && last_bit)
				rxd_reg <= shift_next;
		end
	end

	assign o_tx_ready = ready_reg;
	assign o_rx_valid = rxv_reg;
	assign o_rx_data = rxd_reg;
	assign o_busy = busy_reg;
	assign o_serial_clock_out = sclk_reg;
	assign o_controller_out_data = mosi_reg;
	assign o_select_n = sel_n_reg;
endmodule
`default_nettype wire

// *** verif/scp_checker.sv ***
// Purpose: Port timing checks for the serial controller
// Assumes: Settings steady while selected
// Notes: Odd periods put the extra cycle in the second half
`timescale 1ns/10ps
`default_nettype none
module scp_checker
(
	input wire logic i_mclk,
	input wire logic i_reset,
	input wire logic [31:0] i_global_control_reg,
	input wire logic [31:0] i_format_config_reg,
	input wire logic [31:0] i_select_delay_reg,
	input wire logic i_select_hold_enable,
	input wire logic i_tx_valid,
	input wire logic o_tx_ready,
	input wire logic o_serial_clock_out,
	input wire logic o_controller_out_data,
	input wire logic o_select_n
);
	import scp_pkg::*;
	// ***
	// Edge and gap counters
	// ***
	logic sclk_q_reg;
	logic [9:0] gap_reg, quiet_reg, edges_reg;
	wire logic pol = i_format_config_reg[FMT_POL_BIT];
	wire logic [7:0] ps = i_format_config_reg[FMT_PS_MSB:FMT_PS_LSB];
	wire logic [9:0] half = {3'h0, ps[7:1]} + {9'h000, ps[0] | ~|ps};
	wire logic [9:0] period = (ps == 8'h00) ? PS_ZERO_CYC
		: {2'h0, ps} + 10'h001;
	wire logic [9:0] lead_in = {2'h0, i_select_delay_reg[DLY_C2T_LSB +: DLY_W]}
		+ SETUP_EXTRA + {9'h000, pol & i_select_hold_enable} + half;
	wire logic [9:0] rel = {2'h0, i_select_delay_reg[DLY_T2C_LSB +: DLY_W]};
	wire logic moved = o_serial_clock_out != sclk_q_reg;
	always_ff @(posedge i_mclk)
	begin
		sclk_q_reg <= i_reset ? 1'b0 : o_serial_clock_out;
		quiet_reg <= (i_reset || moved) ? 10'h000 : quiet_reg + 10'h001;
		gap_reg <= o_select_n ? 10'h000 : gap_reg + 10'h001;
		edges_reg <= o_select_n ? 10'h000 : edges_reg + {9'h000, moved};
	end
	default clocking cb @(posedge i_mclk);
	endclocking
	default disable iff (i_reset);
	sequence take_s;
		i_tx_valid && o_tx_ready;
	endsequence
	sequence first_s;
		moved && !o_select_n && edges_reg == 10'h000;
	endsequence
	sequence trail_s;
		moved && !o_select_n && o_serial_clock_out == pol;
	endsequence
	sequence lead_s;
		moved && !o_select_n && o_serial_clock_out != pol
			&& edges_reg[4:0] != 5'h00;
	endsequence
	a_setup_gap: assert property (first_s |-> gap_reg == lead_in)
		else $error("setup gap wrong");
	a_release_gap: assert property ($rose(o_select_n) |-> quiet_reg == rel)
		else $error("release gap wrong");
	a_word_edges: assert property ($rose(o_select_n) |->
		edges_reg[4:0] == 5'h00 && edges_reg != 10'h000)
		else $error("edge count wrong");
	a_half_phase: assert property (trail_s |->
		quiet_reg + 10'h001 == period - half)
		else $error("half period wrong");
	a_lead_phase: assert property (lead_s |->
		quiet_reg + 10'h001 == half)
		else $error("first half wrong");
	a_idle_level: assert property (o_select_n && !$past(i_reset)
		&& $stable(i_format_config_reg) |-> o_serial_clock_out == pol)
		else $error("idle level wrong");
	a_mode_gate: assert property (!i_global_control_reg[GCR_CTRL_BIT]
		|| !i_format_config_reg[FMT_PHASE_BIT] |=> !o_tx_ready)
		else $error("ready outside mode");
	a_take_select: assert property (take_s |=> !o_select_n)
		else $error("select late");
	a_data_hold: assert property (!o_select_n && $past(o_serial_clock_out) != pol
		|-> $stable(o_controller_out_data)) else $error("data moved");
endmodule
bind scp_controller scp_checker chk
(
	.i_mclk(i_mclk), .i_reset(i_reset), .i_tx_valid(i_tx_valid),
	.i_global_control_reg(i_global_control_reg),
	.i_format_config_reg(i_format_config_reg),
	.i_select_delay_reg(i_select_delay_reg),
	.i_select_hold_enable(i_select_hold_enable), .o_tx_ready(o_tx_ready),
	.o_serial_clock_out(o_serial_clock_out), .o_select_n(o_select_n),
	.o_controller_out_data(o_controller_out_data)
);
`default_nettype wire

// *** verif/scp_target_model.sv ***
// Purpose: Serial target answering the controller
// Assumes: Clock phase one framing
// Notes: Slower data launch with polarity one
`timescale 1ns/10ps
`default_nettype none
module scp_target_model
(
	input wire logic i_pol,
	input wire logic i_sclk,
	input wire logic i_select_n,
	input wire logic i_controller_out_data,
	input wire logic [15:0] i_reply,
	output logic o_target_out_data,
	output logic [15:0] o_got
);
	// ***
	// Leading edge drives, trailing edge samples
	// ***
	logic [15:0] shift_reg;
	logic [3:0] bit_reg;
	initial
	begin
		o_target_out_data = 1'b0;
		bit_reg = 4'h0;
	end
	// Released line shows the inverse level
	always @(posedge i_select_n)
	begin
		bit_reg = 4'h0;
		o_target_out_data <= #5 ~o_target_out_data;
	end
	always @(i_sclk)
		if (!i_select_n && i_sclk != i_pol)
		begin
			if (bit_reg == 4'h0)
				shift_reg = i_reply;
			o_target_out_data <= #(i_pol ? 12 : 1) shift_reg[15];
			shift_reg = {shift_reg[14:0], 1'b0};
			bit_reg = bit_reg + 4'h1;
		end
		else if (!i_select_n)
			o_got = {o_got[14:0], i_controller_out_data};
endmodule
`default_nettype wire

// *** verif/tb_scp_controller.sv ***
// Purpose: Word transfers through the serial controller
// Assumes: Target model on the far side
// Notes: Settings change only while idle
`timescale 1ns/10ps
`default_nettype none
module tb_scp_controller;
	// ***
	// Bench signals and tasks
	// ***
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic valid = 1'b0;
	logic hold = 1'b0;
	logic [31:0] gcr = 32'h0000_0001;
	logic [31:0] fmt = 32'h0001_0000;
	logic [31:0] dly = 32'h0000_0000;
	logic [15:0] txd = 16'h0000;
	logic [15:0] reply = 16'h0000;
	logic [15:0] rxd, got;
	logic somi, ready, rxv, sclk, simo, seln, busy;
	int failures = 0, n_tests = 0, rises = 0;
	always #10 mclk = ~mclk;
	always @(posedge seln) rises++;
	scp_controller #(.W(16)) dut
	(
		.i_mclk(mclk), .i_reset(rst), .i_global_control_reg(gcr),
		.i_format_config_reg(fmt), .i_select_delay_reg(dly),
		.i_select_hold_enable(hold), .i_tx_valid(valid), .i_tx_data(txd),
		.i_target_out_data(somi), .o_tx_ready(ready), .o_rx_valid(rxv),
		.o_rx_data(rxd), .o_busy(busy), .o_serial_clock_out(sclk),
		.o_controller_out_data(simo), .o_select_n(seln)
	);
	scp_target_model target
	(
		.i_pol(fmt[17]), .i_sclk(sclk), .i_select_n(seln),
		.i_controller_out_data(simo), .i_reply(reply),
		.o_target_out_data(somi), .o_got(got)
	);
	task automatic check(input string what, input logic [15:0] exp,
		input logic [15:0] seen);
		n_tests++;
		if (exp !== seen)
		begin
			failures++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic report_and_stop();
		if (failures == 0 && n_tests > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	function automatic logic pick(input int which);
		case (which)
			0: return ready;
			1: return rxv;
			default: return seln;
		endcase
	endfunction
	task automatic wait_for(input int which, input logic lvl);
		int k;
		k = 0;
		while (pick(which) !== lvl && k < 3000)
		begin
			@(negedge mclk);
			k++;
		end
		if (k == 3000)
			failures++;
	endtask
	task automatic gate(input logic [31:0] g, input logic [31:0] f);
		@(negedge mclk);
		gcr = g;
		fmt = f;
		@(negedge mclk);
		valid = 1'b1;
		repeat (20) @(negedge mclk);
		check("refused", 16'h0002, {14'h0000, seln, ready});
		valid = 1'b0;
		gcr = 32'h0000_0001;
	endtask
	task automatic run(input logic [7:0] ps, input logic pol,
		input logic [7:0] su, input logic [7:0] rl, input logic h, input int n);
		int r0;
		logic [15:0] w;
		@(negedge mclk);
		fmt = {14'h0000, pol, 1'b1, ps, 8'h00};
		dly = {su, rl, 16'h0000};
		hold = h;
		reply = {rl, su} ^ 16'hA55A;
		r0 = rises;
		for (int i = 0; i < n; i++)
		begin
			w = {ps, 8'(i)} ^ 16'h3CC3;
			@(negedge mclk);
			valid = 1'b1;
			txd = w;
			wait_for(0, 1'b1);
			@(negedge mclk);
			valid = 1'b0;
			wait_for(1, 1'b1);
			check("rx_data", reply, rxd);
			check("target_word", w, got);
			check("busy_word", 16'h0001, {15'h0000, busy});
		end
		wait_for(2, 1'b1);
		check("select_releases", 16'h0001, 16'(rises - r0));
		check("busy_idle", 16'h0000, {15'h0000, busy});
	endtask
	initial
	begin
		#400000;
		failures++;
		report_and_stop();
	end
	initial
	begin
		repeat (10) @(posedge mclk);
		@(negedge mclk);
		rst = 1'b0;
		gate(32'h0000_0000, 32'h0001_0000);
		gate(32'h0000_0001, 32'h0000_0000);
		run(8'h00, 1'b0, 8'h00, 8'h00, 1'b0, 1);
		run(8'h03, 1'b1, 8'h02, 8'h01, 1'b0, 1);
		run(8'h01, 1'b1, 8'h01, 8'h03, 1'b1, 2);
		run(8'h03, 1'b0, 8'h04, 8'h02, 1'b1, 1);
		run(8'h02, 1'b0, 8'h01, 8'h00, 1'b0, 1);
		report_and_stop();
	end
endmodule
`default_nettype wire
